// file: config_fuse_decode.sv
// Configuration byte loader, decoder and lock logic with APB access
// Operation
// R1: One-way vector lock: one set, then locked
// R2: Otherwise vector lock toggles, each after unlock
// R3: Multivector option selects vector table dispatch
// R4: Power-up timer field selects off/64/16/1 ms
// R5: Without low-voltage programming, option picks pin role
// R6: Low-voltage programming forces pin to reset
// R7: Refuse clearing low-voltage option during its programming
// R8: Extended instruction option zero enables extended set
// R9: Stack fault resets only when option set
// R10: One-way pin-select lock set once, then frozen
// R11: Otherwise pin-select lock toggles after unlock
// R12: Zero-cross default zero forces detector on
// R13: Watchdog modes 11/10 ignore software enable
// R14: Mode 01 software enabled, 00 always off
// R15: Preset copied to period at power-on
// R16: Preset 11111 loads 01011, period stays writable
// R17: Bytes sampled at reset, settings held constant
// R18: Unimplemented bits stored, never affect decode
`timescale 1ns/100ps
`default_nettype none
module config_fuse_decode #(
  parameter int POWERUP_TIMER_LONG_CYC = config_fuse_pkg::POWERUP_TIMER_LONG_CYC,
  parameter int POWERUP_TIMER_MID_CYC = config_fuse_pkg::POWERUP_TIMER_MID_CYC,
  parameter int POWERUP_TIMER_SHORT_CYC = config_fuse_pkg::POWERUP_TIMER_SHORT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] nv_byte_three,
  input wire logic [7:0] nv_byte_four,
  input wire logic [7:0] nv_byte_five,
  input wire logic lvp_prog_active,
  input wire logic sleep_active,
  input wire logic stack_fault,
  output config_fuse_pkg::settings_t settings
);

  typedef struct packed {
    config_fuse_pkg::phase_t phase;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic [7:0] lat3;
    logic [7:0] lat4;
    logic [7:0] lat5;
    logic [1:0] unlock;
    logic vt_used;
    logic wdt_sw_en;
    logic zcd_sw_en;
    logic zcd_md;
    logic [config_fuse_pkg::POWERUP_TIMER_W-1:0] powerup_timer_cnt;
    logic [2:0] lvp_sync;
    logic lvp_active;
    logic [31:0] rdata;
    logic ready;
    logic err;
    config_fuse_pkg::settings_t set;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic access;
  logic commit;
  logic [29:0] idx;
  logic mapped;
  logic refuse;
  logic [31:0] rd;
  logic [7:0] wb;
  logic vt_one_way;
  logic ps_one_way;
  logic preset_soft;
  logic [1:0] wdt_mode;
  logic [4:0] preset;

  assign idx = paddr[31:2];
  assign wb = pwdata[7:0];
  assign access = psel & penable;
  // Write lands only on the edge where the master sees pready
  assign commit = access & st_reg.ready;
  assign vt_one_way = st_reg.lat3[config_fuse_pkg::POS_VT_ONE_WAY];
  assign ps_one_way = st_reg.lat4[config_fuse_pkg::POS_PS_ONE_WAY];
  assign wdt_mode = st_reg.lat5[config_fuse_pkg::POS_WDT_MODE +: 2];
  assign preset = st_reg.lat5[config_fuse_pkg::POS_WDT_PRESET +: 5];
  assign preset_soft = (preset == config_fuse_pkg::PRESET_SOFT); // R16

  // Address decode, read mux and refusal check
  always_comb begin
    mapped = 1'b1;
    refuse = 1'b0;
    rd = 32'h00000000;
    unique case (idx)
      config_fuse_pkg::IDX_CFG_THREE: rd[7:0] = st_reg.cfg3; // R18
      config_fuse_pkg::IDX_CFG_FOUR: begin
        rd[7:0] = st_reg.cfg4;
        // Dropping out of low-voltage mode mid-programming is blocked
        refuse = st_reg.lvp_active & ~wb[config_fuse_pkg::POS_LVP]; // R7
      end
      config_fuse_pkg::IDX_CFG_FIVE: rd[7:0] = st_reg.cfg5;
      config_fuse_pkg::IDX_LOCK: begin
        rd[config_fuse_pkg::POS_VT_LOCK] = st_reg.set.vector_table_lock;
        rd[config_fuse_pkg::POS_PS_LOCK] = st_reg.set.pinselect_lock;
        // Lock changes need the full unlock sequence first
        refuse = (st_reg.unlock != 2'h2); // R2 R11
        if (vt_one_way && st_reg.vt_used &&
            wb[config_fuse_pkg::POS_VT_LOCK] != st_reg.set.vector_table_lock) begin
          refuse = 1'b1; // R1
        end
        if (ps_one_way && st_reg.set.pinselect_lock &&
            !wb[config_fuse_pkg::POS_PS_LOCK]) begin
          refuse = 1'b1; // R10
        end
      end
      config_fuse_pkg::IDX_UNLOCK: rd[1:0] = st_reg.unlock;
      config_fuse_pkg::IDX_WDT_CTRL: begin
        rd[config_fuse_pkg::POS_SW_EN] = st_reg.wdt_sw_en;
        rd[config_fuse_pkg::POS_PERIOD +: 5] = st_reg.set.watchdog_period_field;
      end
      config_fuse_pkg::IDX_ZCD_CTRL: begin
        rd[config_fuse_pkg::POS_SW_EN] = st_reg.zcd_sw_en;
        rd[config_fuse_pkg::POS_ZCD_MD] = st_reg.zcd_md;
      end
      config_fuse_pkg::IDX_STATUS: begin
        rd[0] = st_reg.set.powerup_timer_done;
        rd[1] = st_reg.lvp_active;
        rd[2] = st_reg.set.watchdog_run;
        rd[3] = st_reg.set.zero_cross_on;
        rd[4] = st_reg.set.external_reset_input;
        rd[5] = (st_reg.phase == config_fuse_pkg::PH_RUN);
      end
      default: mapped = 1'b0;
    endcase
    // Misaligned or unmapped: error, reads zero
    if (paddr[1:0] != 2'h0 || !mapped) begin
      rd = 32'h00000000;
      refuse = 1'b1;
    end
    // Status word cannot be written
    if (pwrite && idx == config_fuse_pkg::IDX_STATUS) begin
      refuse = 1'b1;
    end
    if (!pwrite) begin
      refuse = refuse & ~mapped | (paddr[1:0] != 2'h0);
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;

    // Three-stage pin synchroniser; level moves when stages two and three agree
    st_next.lvp_sync = {st_reg.lvp_sync[1:0], lvp_prog_active};
    if (st_reg.lvp_sync[1] == st_reg.lvp_sync[2]) begin
      st_next.lvp_active = st_reg.lvp_sync[2];
    end

    unique case (st_reg.phase)
      config_fuse_pkg::PH_LOAD: begin
        // Capture storage once, right after reset release
        st_next.cfg3 = nv_byte_three; // R17
        st_next.cfg4 = nv_byte_four;
        st_next.cfg5 = nv_byte_five;
        st_next.lat3 = nv_byte_three; // R17
        st_next.lat4 = nv_byte_four;
        st_next.lat5 = nv_byte_five;
        // Power-on period copy from preset
        if (nv_byte_five[config_fuse_pkg::POS_WDT_PRESET +: 5] == config_fuse_pkg::PRESET_SOFT) begin
          st_next.set.watchdog_period_field = config_fuse_pkg::PERIOD_SOFT_RESET; // R16
        end else begin
          st_next.set.watchdog_period_field = nv_byte_five[config_fuse_pkg::POS_WDT_PRESET +: 5]; // R15
        end
        // Timer length from the two-bit selector
        unique case (nv_byte_three[config_fuse_pkg::POS_POWERUP_TIMER_SEL +: 2])
          config_fuse_pkg::POWERUP_TIMER_OFF: st_next.powerup_timer_cnt = '0; // R4
          config_fuse_pkg::POWERUP_TIMER_LONG: st_next.powerup_timer_cnt = POWERUP_TIMER_LONG_CYC[config_fuse_pkg::POWERUP_TIMER_W-1:0]; // R4
          config_fuse_pkg::POWERUP_TIMER_MID: st_next.powerup_timer_cnt = POWERUP_TIMER_MID_CYC[config_fuse_pkg::POWERUP_TIMER_W-1:0]; // R4
          default: st_next.powerup_timer_cnt = POWERUP_TIMER_SHORT_CYC[config_fuse_pkg::POWERUP_TIMER_W-1:0]; // R4
        endcase
        st_next.phase = config_fuse_pkg::PH_RUN;
      end
      config_fuse_pkg::PH_RUN: begin
        if (st_reg.powerup_timer_cnt != '0) begin
          st_next.powerup_timer_cnt = st_reg.powerup_timer_cnt - 1'b1;
        end
      end
    endcase

    // APB answer: one wait state, then pready for one cycle
    st_next.ready = 1'b0;
    if (access && !st_reg.ready) begin
      st_next.ready = 1'b1;
      st_next.err = refuse;
      st_next.rdata = pwrite ? 32'h00000000 : rd;
    end

    // Register writes; image changes here never reach the decoded settings
    if (commit && pwrite && !refuse && st_reg.phase == config_fuse_pkg::PH_RUN) begin
      unique case (idx)
        config_fuse_pkg::IDX_CFG_THREE: st_next.cfg3 = wb; // R18
        config_fuse_pkg::IDX_CFG_FOUR: st_next.cfg4 = wb; // R7
        config_fuse_pkg::IDX_CFG_FIVE: st_next.cfg5 = wb;
        config_fuse_pkg::IDX_LOCK: begin
          if (wb[config_fuse_pkg::POS_VT_LOCK] && !st_reg.set.vector_table_lock && vt_one_way) begin
            st_next.vt_used = 1'b1; // R1
          end
          st_next.set.vector_table_lock = wb[config_fuse_pkg::POS_VT_LOCK]; // R1 R2
          st_next.set.pinselect_lock = wb[config_fuse_pkg::POS_PS_LOCK]; // R10 R11
        end
        config_fuse_pkg::IDX_WDT_CTRL: begin
          st_next.wdt_sw_en = wb[config_fuse_pkg::POS_SW_EN];
          if (preset_soft) begin
            st_next.set.watchdog_period_field = wb[config_fuse_pkg::POS_PERIOD +: 5]; // R16
          end
        end
        config_fuse_pkg::IDX_ZCD_CTRL: begin
          st_next.zcd_sw_en = wb[config_fuse_pkg::POS_SW_EN];
          st_next.zcd_md = wb[config_fuse_pkg::POS_ZCD_MD];
        end
        default: st_next.rdata = st_reg.rdata;
      endcase
    end

    // Unlock sequencer: any other completed write drops the arming
    if (commit && pwrite) begin
      if (idx == config_fuse_pkg::IDX_UNLOCK && paddr[1:0] == 2'h0) begin
        if (wb == config_fuse_pkg::UNLOCK_KEY_A) begin
          st_next.unlock = 2'h1;
        end else if (wb == config_fuse_pkg::UNLOCK_KEY_B && st_reg.unlock == 2'h1) begin
          st_next.unlock = 2'h2;
        end else begin
          st_next.unlock = 2'h0;
        end
      end else begin
        st_next.unlock = 2'h0;
      end
    end

    // Decoded outputs; option bits come from latched bytes only, never from the writable image
    st_next.set.multivector_enable = st_reg.lat3[config_fuse_pkg::POS_MULTIVECTOR]; // R3
    st_next.set.extended_instr_enable = ~st_reg.lat4[config_fuse_pkg::POS_EXT_INSTR]; // R8
    st_next.set.external_reset_input = st_reg.lat4[config_fuse_pkg::POS_LVP] | // R6
      st_reg.lat3[config_fuse_pkg::POS_RESET_PIN]; // R5
    // Fault is a one-cycle request; no stretch needed by the sequencer
    st_next.set.stack_reset_req = stack_fault & st_reg.lat4[config_fuse_pkg::POS_STACK_RST]; // R9
    if (!st_reg.lat4[config_fuse_pkg::POS_ZCD_DEFAULT]) begin
      st_next.set.zero_cross_on = 1'b1; // R12
    end else begin
      st_next.set.zero_cross_on = st_reg.zcd_sw_en & ~st_reg.zcd_md; // R12
    end
    unique case (wdt_mode)
      config_fuse_pkg::WDT_ALWAYS: st_next.set.watchdog_run = 1'b1; // R13
      config_fuse_pkg::WDT_AWAKE: st_next.set.watchdog_run = ~sleep_active; // R13
      config_fuse_pkg::WDT_SOFT: st_next.set.watchdog_run = st_reg.wdt_sw_en; // R14
      default: st_next.set.watchdog_run = 1'b0; // R14
    endcase
    // Codes above the top step fold back to the base prescale
    if (st_reg.set.watchdog_period_field <= config_fuse_pkg::PERIOD_MAX_CODE) begin
      st_next.set.watchdog_div_log2 = st_reg.set.watchdog_period_field +
        config_fuse_pkg::PRESCALE_BASE_LOG2; // R15
    end else begin
      st_next.set.watchdog_div_log2 = config_fuse_pkg::PRESCALE_BASE_LOG2; // R15
    end
    st_next.set.powerup_timer_done = (st_reg.phase == config_fuse_pkg::PH_RUN) &&
      (st_reg.powerup_timer_cnt == '0); // R4

    // Nothing runs until the bytes are captured
    if (st_reg.phase == config_fuse_pkg::PH_LOAD) begin
      st_next.set.watchdog_run = 1'b0;
      st_next.set.stack_reset_req = 1'b0;
    end
  end

  // State register; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.phase <= config_fuse_pkg::PH_LOAD;
      st_reg.cfg3 <= config_fuse_pkg::CFG_RESET;
      st_reg.cfg4 <= config_fuse_pkg::CFG_RESET;
      st_reg.cfg5 <= config_fuse_pkg::CFG_RESET;
      st_reg.lat3 <= config_fuse_pkg::CFG_RESET;
      st_reg.lat4 <= config_fuse_pkg::CFG_RESET;
      st_reg.lat5 <= config_fuse_pkg::CFG_RESET;
      st_reg.rdata <= config_fuse_pkg::RDATA_RESET;
      st_reg.set.external_reset_input <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign settings = st_reg.set;

endmodule // config_fuse_decode
`default_nettype wire

// file: config_fuse_pkg.sv
// Shared constants and types for the configuration decode block
package config_fuse_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [29:0] IDX_CFG_THREE = 30'h00300002;
  localparam logic [29:0] IDX_CFG_FOUR = 30'h00300003;
  localparam logic [29:0] IDX_CFG_FIVE = 30'h00300004;
  localparam logic [29:0] IDX_LOCK = 30'h00300010;
  localparam logic [29:0] IDX_UNLOCK = 30'h00300011;
  localparam logic [29:0] IDX_WDT_CTRL = 30'h00300012;
  localparam logic [29:0] IDX_ZCD_CTRL = 30'h00300013;
  localparam logic [29:0] IDX_STATUS = 30'h00300014;

  // Byte three fields
  localparam int POS_VT_ONE_WAY = 4;
  localparam int POS_MULTIVECTOR = 3;
  localparam int POS_POWERUP_TIMER_SEL = 1;
  localparam int POS_RESET_PIN = 0;
  // Byte four fields
  localparam int POS_EXT_INSTR = 7;
  localparam int POS_LVP = 5;
  localparam int POS_STACK_RST = 4;
  localparam int POS_PS_ONE_WAY = 3;
  localparam int POS_ZCD_DEFAULT = 2;
  // Byte five fields
  localparam int POS_WDT_MODE = 5;
  localparam int POS_WDT_PRESET = 0;
  // Control register fields
  localparam int POS_VT_LOCK = 0;
  localparam int POS_PS_LOCK = 1;
  localparam int POS_SW_EN = 0;
  localparam int POS_PERIOD = 1;
  localparam int POS_ZCD_MD = 1;

  // Unlock keys, written in this order
  localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_B = 8'hAA;

  // Field codes
  localparam logic [1:0] POWERUP_TIMER_OFF = 2'h3;
  localparam logic [1:0] POWERUP_TIMER_LONG = 2'h2;
  localparam logic [1:0] POWERUP_TIMER_MID = 2'h1;
  localparam logic [1:0] WDT_ALWAYS = 2'h3;
  localparam logic [1:0] WDT_AWAKE = 2'h2;
  localparam logic [1:0] WDT_SOFT = 2'h1;
  localparam logic [4:0] PRESET_SOFT = 5'h1F;
  localparam logic [4:0] PERIOD_SOFT_RESET = 5'h0B;
  localparam logic [4:0] PERIOD_MAX_CODE = 5'h12;
  localparam logic [4:0] PRESCALE_BASE_LOG2 = 5'h05;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // Power-up timer
  localparam int CLK_HZ = 40000000;
  localparam int POWERUP_TIMER_LONG_MS = 64;
  localparam int POWERUP_TIMER_MID_MS = 16;
  localparam int POWERUP_TIMER_SHORT_MS = 1;
  localparam int POWERUP_TIMER_LONG_CYC = CLK_HZ / 1000 * POWERUP_TIMER_LONG_MS;
  localparam int POWERUP_TIMER_MID_CYC = CLK_HZ / 1000 * POWERUP_TIMER_MID_MS;
  localparam int POWERUP_TIMER_SHORT_CYC = CLK_HZ / 1000 * POWERUP_TIMER_SHORT_MS;
  localparam int POWERUP_TIMER_W = 22;

  typedef enum logic [1:0] {
    PH_LOAD = 2'b01,
    PH_RUN = 2'b10
  } phase_t;

  // Decoded settings handed to the rest of the chip
  typedef struct packed {
    logic multivector_enable;
    logic extended_instr_enable;
    logic external_reset_input;
    logic stack_reset_req;
    logic vector_table_lock;
    logic pinselect_lock;
    logic zero_cross_on;
    logic watchdog_run;
    logic [4:0] watchdog_period_field;
    logic [4:0] watchdog_div_log2;
    logic powerup_timer_done;
  } settings_t;

endpackage

// file: config_fuse_decode_assertions.sv
// Port-level checks for the configuration decode block
`timescale 1ns/100ps
`default_nettype none
module config_fuse_decode_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] nv_byte_three,
  input wire logic [7:0] nv_byte_four,
  input wire logic [7:0] nv_byte_five,
  input wire logic lvp_prog_active,
  input wire logic sleep_active,
  input wire logic stack_fault,
  input wire config_fuse_pkg::settings_t settings
);
  logic [1:0] cnt_reg;
  logic [7:0] b3_reg;
  logic [7:0] b4_reg;
  logic [7:0] b5_reg;
  logic ready;
  // Decode is judged only once the load cycle is over
  assign ready = (cnt_reg == 2'h3);
  // Cycles since reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
    end else if (cnt_reg != 2'h3) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  // Own copy from the load cycle, so later byte rewrites cannot leak in
  always_ff @(posedge pclk) begin
    if (cnt_reg == 2'h0) begin
      b3_reg <= nv_byte_three;
      b4_reg <= nv_byte_four;
      b5_reg <= nv_byte_five;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_start;
    psel && penable && !pready;
  endsequence
  sequence one_pulse;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (access_start |=> one_pulse)
    else $error("pready not one pulse after one wait");
  a_multivector_map: assert property (ready |-> settings.multivector_enable == b3_reg[3])
    else $error("multivector setting wrong");
  a_ext_instr_map: assert property (ready |-> settings.extended_instr_enable == !b4_reg[7])
    else $error("extended instruction setting wrong");
  a_reset_pin_role: assert property (
    ready |-> settings.external_reset_input == (b4_reg[5] | b3_reg[0]))
    else $error("reset pin role wrong");
  a_stack_fault_rst: assert property (
    ready |=> settings.stack_reset_req == ($past(stack_fault) & b4_reg[4]))
    else $error("stack fault reset wrong");
  a_zero_cross_forced: assert property (ready && !b4_reg[2] |-> settings.zero_cross_on)
    else $error("zero-cross not forced on");
  a_watchdog_mode: assert property (
    ready && b5_reg[6:5] != 2'h1 && $stable(sleep_active) && sleep_active == $past(sleep_active, 2)
    |-> settings.watchdog_run == (b5_reg[6] & (b5_reg[5] | !sleep_active)))
    else $error("watchdog run state wrong");
  a_period_locked: assert property (
    ready && b5_reg[4:0] != 5'h1F |-> settings.watchdog_period_field == b5_reg[4:0])
    else $error("period field not the preset");
  // Divider lags the period field by one clock, so judge it against last cycle's period
  a_period_divider: assert property (ready |-> settings.watchdog_div_log2 ==
    ($past(settings.watchdog_period_field) <= 5'h12 ? $past(settings.watchdog_period_field) + 5'h05 : 5'h05))
    else $error("period divider wrong");
endmodule // config_fuse_decode_assertions
bind config_fuse_decode config_fuse_decode_assertions i_config_fuse_decode_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nv_byte_three(nv_byte_three), .nv_byte_four(nv_byte_four), .nv_byte_five(nv_byte_five),
  .lvp_prog_active(lvp_prog_active), .sleep_active(sleep_active), .stack_fault(stack_fault),
  .settings(settings));
`default_nettype wire

// file: config_fuse_decode_tb.sv
// Self-checking bench for the configuration decode block
`timescale 1ns/100ps
`default_nettype none
module config_fuse_decode_tb;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, er, lvp_prog_active, sleep_active, stack_fault;
  logic pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] nv_byte_three, nv_byte_four, nv_byte_five;
  config_fuse_pkg::settings_t settings;
  int n_fail = 0;
  int n_tests = 0;
  // Short timer counts keep the power-up test brief
  config_fuse_decode #(.POWERUP_TIMER_LONG_CYC(40), .POWERUP_TIMER_MID_CYC(20), .POWERUP_TIMER_SHORT_CYC(10)) i_config_fuse_decode (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_byte_three(nv_byte_three), .nv_byte_four(nv_byte_four), .nv_byte_five(nv_byte_five),
    .lvp_prog_active(lvp_prog_active), .sleep_active(sleep_active), .stack_fault(stack_fault),
    .settings(settings));
  always #12.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One transfer; request held until pready is seen at an edge, a hang is left to the watchdog
  task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wre(input logic [29:0] idx, input logic [31:0] d, input logic e);
    apb(1'h1, idx, d);
    chk(er, e);
  endtask

  // Lock write, optionally preceded by the two unlock keys
  task automatic lockw(input logic [31:0] d, input logic e, input logic arm);
    if (arm) begin
      wre(config_fuse_pkg::IDX_UNLOCK, 32'h55, 1'h0);
      wre(config_fuse_pkg::IDX_UNLOCK, 32'hAA, 1'h0);
    end
    wre(config_fuse_pkg::IDX_LOCK, d, e);
  endtask

  // Reset with fresh storage bytes, then wait out the load cycle
  task automatic boot(input logic [7:0] b3, input logic [7:0] b4, input logic [7:0] b5);
    @(posedge pclk);
    presetn <= 1'h0;
    nv_byte_three <= b3;
    nv_byte_four <= b4;
    nv_byte_five <= b5;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
  endtask

  task automatic pulse_fault;
    stack_fault <= 1'h1;
    @(posedge pclk);
    stack_fault <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic t_decode;
    boot(8'h08, 8'h40, 8'h65);
    chk(settings.multivector_enable, 1'h1);
    chk(settings.extended_instr_enable, 1'h1);
    chk(settings.external_reset_input, 1'h0);
    chk(settings.zero_cross_on, 1'h1);
    chk(settings.watchdog_run, 1'h1);
    chk({settings.watchdog_period_field, settings.watchdog_div_log2}, {5'h05, 5'h0A});
    apb(1'h0, config_fuse_pkg::IDX_CFG_FOUR, 32'h0);
    chk(rd, 32'h40);
    pulse_fault();
    chk(settings.stack_reset_req, 1'h0);
    nv_byte_four <= 8'hFF;
    nv_byte_three <= 8'h01;
    repeat (4) @(posedge pclk);
    chk({settings.extended_instr_enable, settings.external_reset_input}, 2'h2);
    apb(1'h0, 30'h00300030, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
    wre(config_fuse_pkg::IDX_STATUS, 32'h0, 1'h1);
    apb(1'h0, config_fuse_pkg::IDX_STATUS, 32'h0);
    chk(rd, 32'h2D);
  endtask

  // Every power-up timer code against its reduced count; off means done at once
  task automatic t_powerup_timer;
    int n;
    int ex [4] = '{10, 20, 40, 0};
    for (int c = 0; c < 4; c++) begin
      boot({5'h1F, c[1:0], 1'h1}, 8'hFF, 8'hFF);
      n = 0;
      while (settings.powerup_timer_done !== 1'h1 && n < 100) begin
        @(posedge pclk);
        n++;
      end
      chk(n + 4 >= ex[c] && n <= ex[c] + 2, 1'h1);
    end
  endtask

  task automatic t_lock;
    boot(8'hFF, 8'hFF, 8'hFF);
    lockw(32'h1, 1'h1, 1'h0);
    lockw(32'h1, 1'h0, 1'h1);
    lockw(32'h0, 1'h1, 1'h1);
    lockw(32'h3, 1'h0, 1'h1);
    lockw(32'h1, 1'h1, 1'h1);
    chk({settings.vector_table_lock, settings.pinselect_lock}, 2'h3);
    pulse_fault();
    chk(settings.stack_reset_req, 1'h1);
    boot(8'hEF, 8'hF7, 8'hFF);
    lockw(32'h3, 1'h0, 1'h1);
    lockw(32'h0, 1'h0, 1'h1);
    repeat (2) @(posedge pclk);
    chk({settings.vector_table_lock, settings.pinselect_lock}, 2'h0);
    lockw(32'h1, 1'h1, 1'h0);
  endtask

  task automatic t_lvp;
    lvp_prog_active <= 1'h1;
    repeat (6) @(posedge pclk);
    wre(config_fuse_pkg::IDX_CFG_FOUR, 32'hDF, 1'h1);
    wre(config_fuse_pkg::IDX_CFG_FOUR, 32'hBE, 1'h0);
    apb(1'h0, config_fuse_pkg::IDX_CFG_FOUR, 32'h0);
    chk(rd, 32'hBE);
    lvp_prog_active <= 1'h0;
    repeat (6) @(posedge pclk);
    wre(config_fuse_pkg::IDX_CFG_FOUR, 32'hDF, 1'h0);
  endtask

  // Modes with sleep and software enable, then the writable period
  task automatic t_wdt;
    for (int m = 0; m < 4; m++) begin
      boot(8'hFF, 8'hFF, {1'h1, m[1:0], 5'h13});
      wre(config_fuse_pkg::IDX_WDT_CTRL, 32'h09, 1'h0);
      repeat (3) @(posedge pclk);
      chk(settings.watchdog_run, m != 0);
      chk({settings.watchdog_period_field, settings.watchdog_div_log2}, {5'h13, 5'h05});
      sleep_active <= 1'h1;
      wre(config_fuse_pkg::IDX_WDT_CTRL, 32'h0, 1'h0);
      repeat (3) @(posedge pclk);
      chk(settings.watchdog_run, m == 3);
      sleep_active <= 1'h0;
    end
    boot(8'hFE, 8'hFF, 8'h7F);
    chk({settings.watchdog_period_field, settings.watchdog_div_log2, settings.zero_cross_on,
      settings.external_reset_input}, {5'h0B, 5'h10, 1'h0, 1'h1});
    wre(config_fuse_pkg::IDX_WDT_CTRL, 32'h24, 1'h0);
    wre(config_fuse_pkg::IDX_ZCD_CTRL, 32'h1, 1'h0);
    repeat (3) @(posedge pclk);
    chk({settings.watchdog_period_field, settings.watchdog_div_log2, settings.zero_cross_on},
      {5'h12, 5'h17, 1'h1});
    wre(config_fuse_pkg::IDX_ZCD_CTRL, 32'h3, 1'h0);
    repeat (3) @(posedge pclk);
    chk(settings.zero_cross_on, 1'h0);
  endtask

  // Main sequence
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    nv_byte_three = 8'hFF;
    nv_byte_four = 8'hFF;
    nv_byte_five = 8'hFF;
    lvp_prog_active = 1'h0;
    sleep_active = 1'h0;
    stack_fault = 1'h0;
    t_decode();
    t_powerup_timer();
    t_lock();
    t_lvp();
    t_wdt();
    print_verdict();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule // config_fuse_decode_tb
`default_nettype wire
